// File: hdl/eep_i2c_slave.sv
`timescale 1ns/1ps

// Contract
// R1 - STOP is the data line rising while the serial clock is high.
// R2 - The master ends every read or write with a STOP.
// R3 - Upper four bits of the slave address must equal the device code.
// R4 - Address bit zero chooses direction: one reads, zero writes.
// R5 - Acknowledge the slave address only on a match, then read or write.
// R6 - A receiver pulls the data line low during the ninth clock.
// R7 - In write mode every received byte is acknowledged.
// R8 - Reading: send eight bits, release, sample acknowledge, stop if none.
// R9 - Byte write: address, two address bytes, one data byte, STOP.
// R10 - STOP after a write starts programming; requests are ignored meanwhile.
// R11 - A page write takes up to 64 data bytes in one cycle.
// R12 - Each page data byte bumps only the low address bits.
// R13 - Beyond 64 bytes the page address wraps and overwrites earlier bytes.
// R14 - STOP commits all buffered page bytes in a single programming cycle.
// R15 - Polling address is not acknowledged while programming, then is.
// R16 - The address counter holds last location plus one for current reads.
// R17 - The address counter rolls from 4,095 back to zero.
// R18 - Random read is a dummy write then repeated START reading.
// R19 - Sequential read sends a byte per acknowledge, counting all bits.
// R20 - START is the data line falling while the clock is high.
// R21 - The master keeps data stable while the serial clock is high.
// R22 - Supervisor reset aborts transfers and blocks new programming cycles.
// R23 - The memory address is twelve bits; upper first-byte bits ignored.
// R24 - Page incrementing covers the lowest six address bits.
module eep_i2c_slave #(
    parameter logic [3:0] DEV_CODE = eep_pkg::DEV_CODE,
    parameter int         PROG_CYC = eep_pkg::PROG_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl_clk,
    input  wire logic sda_i,
    input  wire logic sup_rst,
    output logic      sda_o,
    output logic      sda_oe,
    output logic      prog_busy
);

    localparam int AW = eep_pkg::ADDR_W;
    localparam int PW = eep_pkg::PAGE_W;
    localparam int BW = eep_pkg::BYTE_W;

    // ==========================================================
    // Parameter checks
    if (PROG_CYC < 1 || PROG_CYC >= (2 ** eep_pkg::PCNT_W)) begin : g_chk
        $error("PROG_CYC out of range");
    end

    // ==========================================================
    // State, link sample and memory
    eep_pkg::eep_core_t sr_reg;
    eep_pkg::eep_core_t sr_next;
    eep_pkg::eep_lnk_t  lnk;
    logic [BW-1:0]      mem [eep_pkg::MEM_N];
    logic [BW-1:0]      mem_q;
    logic               start;
    logic               stop;
    logic               rise;
    logic               fall;
    logic               sup;
    logic               rx_done;
    logic               load;
    logic               code_ok;
    logic [PW-1:0]      pg_pos;

    eep_lnk_cap u_lnk (
        .scl_clk (scl_clk),
        .sda_i   (sda_i),
        .lnk     (lnk)
    );

    // ==========================================================
    // Bus conditions seen through the synchronisers
    assign start = sr_reg.scl_s[1] & sr_reg.scl_s[2]
                 & sr_reg.sda_s[2] & ~sr_reg.sda_s[1]; // R20
    assign stop  = sr_reg.scl_s[1] & sr_reg.scl_s[2]
                 & ~sr_reg.sda_s[2] & sr_reg.sda_s[1]; // R1
    // Rise is taken one stage late so the sampled bit has settled
    assign rise  = sr_reg.scl_s[2] & ~sr_reg.scl_s[3];
    assign fall  = sr_reg.scl_s[2] & ~sr_reg.scl_s[1];
    assign sup   = sr_reg.sup_s[1];
    assign mem_q = mem[sr_reg.addr];

    assign rx_done = (sr_reg.st == eep_pkg::S_RX) && fall
                   && (sr_reg.cnt == eep_pkg::RX_LAST);
    assign code_ok = sr_reg.shf[BW-1:eep_pkg::CODE_LSB] == DEV_CODE; // R3
    assign load    = fall && !start && !stop && !sup
                   && ((sr_reg.st == eep_pkg::S_ACK && sr_reg.rd)
                   || sr_reg.st == eep_pkg::S_RNEXT);
    assign pg_pos  = sr_reg.addr[PW-1:0];

    // ==========================================================
    // Next state
    always_comb begin
        sr_next        = sr_reg;
        sr_next.scl_s  = {sr_reg.scl_s[2:0], scl_clk};
        sr_next.sda_s  = {sr_reg.sda_s[1:0], sda_i};
        sr_next.val_s  = {sr_reg.val_s[0], lnk.val};
        sr_next.sup_s  = {sr_reg.sup_s[0], sup_rst};
        sr_next.lo     = 1'b0;
        sr_next.commit = 1'b0;
        if (sr_reg.commit) begin
            sr_next.pg_vld = '0;
        end
        // A running cycle always completes, reset condition or not
        if (sr_reg.busy) begin // R22
            if (sr_reg.pcnt == '0) begin
                sr_next.busy = 1'b0;
            end else begin
                sr_next.pcnt = sr_reg.pcnt - 1'b1;
            end
        end
        if (sup) begin
            sr_next.st     = eep_pkg::S_IDLE; // R22
            sr_next.oe     = 1'b0;
            sr_next.pg_vld = '0;
        end else if (stop) begin
            sr_next.st = eep_pkg::S_IDLE; // R1
            sr_next.oe = 1'b0;
            if (|sr_reg.pg_vld && !sr_reg.busy) begin
                sr_next.commit = 1'b1; // R14
                sr_next.busy   = 1'b1; // R10
                sr_next.pcnt   = eep_pkg::PCNT_W'(PROG_CYC - 1);
            end
        end else if (start) begin
            sr_next.st  = eep_pkg::S_RX; // R20
            sr_next.cnt = '0;
            sr_next.idx = eep_pkg::IDX_DEV;
            sr_next.oe  = 1'b0;
        end else begin
            case (sr_reg.st)
                eep_pkg::S_RX: begin
                    if (rise && sr_reg.cnt != eep_pkg::RX_LAST) begin
                        sr_next.shf = {sr_reg.shf[BW-2:0], sr_reg.val_s[1]};
                        sr_next.cnt = sr_reg.cnt + 1'b1;
                    end else if (fall && sr_reg.cnt == eep_pkg::RX_LAST) begin
                        sr_next.st = eep_pkg::S_ACK;
                        sr_next.oe = 1'b1; // R6 R7
                        if (sr_reg.idx != eep_pkg::IDX_DATA) begin
                            sr_next.idx =
                                eep_pkg::eep_idx_t'(sr_reg.idx + 1'b1);
                        end
                        case (sr_reg.idx)
                            eep_pkg::IDX_DEV: begin
                                // Busy programming: stay silent to polls
                                if (code_ok && !sr_reg.busy) begin // R5 R15
                                    sr_next.rd =
                                        sr_reg.shf[eep_pkg::DIR_BIT]; // R4
                                    if (!sr_reg.shf[eep_pkg::DIR_BIT]) begin
                                        sr_next.pg_vld = '0;
                                    end
                                end else begin
                                    sr_next.st = eep_pkg::S_IDLE; // R10
                                    sr_next.oe = 1'b0;
                                end
                            end
                            eep_pkg::IDX_HI: begin
                                // Upper bits of this byte fall off the array
                                sr_next.addr[AW-1:BW] =
                                    sr_reg.shf[AW-BW-1:0]; // R23
                            end
                            eep_pkg::IDX_LO: begin
                                sr_next.addr[BW-1:0] = sr_reg.shf;
                            end
                            eep_pkg::IDX_DATA: begin
                                sr_next.pg_buf[pg_pos] = sr_reg.shf;
                                sr_next.pg_vld[pg_pos] = 1'b1; // R11
                                // Page counter wraps, page bits stay put
                                sr_next.addr[PW-1:0] =
                                    pg_pos + 1'b1; // R12 R13 R24
                            end
                            default: begin
                                sr_next.st = eep_pkg::S_IDLE;
                            end
                        endcase
                    end
                end
                eep_pkg::S_ACK: begin
                    if (fall) begin
                        sr_next.cnt = '0;
                        if (sr_reg.rd) begin
                            sr_next.st   = eep_pkg::S_TX;
                            sr_next.shf  = mem_q; // R16
                            sr_next.oe   = ~mem_q[BW-1];
                            sr_next.addr = sr_reg.addr + 1'b1; // R17
                        end else begin
                            sr_next.st = eep_pkg::S_RX;
                            sr_next.oe = 1'b0;
                        end
                    end
                end
                eep_pkg::S_TX: begin
                    if (fall) begin
                        if (sr_reg.cnt == eep_pkg::TX_LAST) begin
                            sr_next.st = eep_pkg::S_RACK; // R8
                            sr_next.oe = 1'b0;
                        end else begin
                            sr_next.shf = {sr_reg.shf[BW-2:0], 1'b0};
                            sr_next.cnt = sr_reg.cnt + 1'b1;
                            sr_next.oe  = ~sr_reg.shf[BW-2];
                        end
                    end
                end
                eep_pkg::S_RACK: begin
                    if (rise) begin
                        if (sr_reg.val_s[1]) begin
                            sr_next.st = eep_pkg::S_IDLE; // R8
                        end else begin
                            sr_next.st = eep_pkg::S_RNEXT;
                        end
                    end
                end
                eep_pkg::S_RNEXT: begin
                    if (fall) begin
                        sr_next.st   = eep_pkg::S_TX;
                        sr_next.cnt  = '0;
                        sr_next.shf  = mem_q; // R19
                        sr_next.oe   = ~mem_q[BW-1];
                        sr_next.addr = sr_reg.addr + 1'b1; // R17 R19
                    end
                end
                eep_pkg::S_IDLE: begin
                    sr_next.oe = 1'b0;
                end
                default: begin
                    sr_next.st = eep_pkg::S_IDLE;
                    sr_next.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sr_reg       <= '0;
            // Idle bus levels, so no false edge follows reset
            sr_reg.scl_s <= '1;
            sr_reg.sda_s <= '1;
        end else begin
            sr_reg <= sr_next;
        end
    end

    // ==========================================================
    // Array: one page lands in a single cycle at commit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < eep_pkg::MEM_N; i++) begin
                mem[i] <= eep_pkg::ERASED;
            end
        end else if (sr_reg.commit) begin
            for (int i = 0; i < eep_pkg::PAGE_N; i++) begin
                if (sr_reg.pg_vld[i]) begin // R14
                    mem[{sr_reg.addr[AW-1:PW], PW'(i)}] <= sr_reg.pg_buf[i];
                end
            end
        end
    end

    // ==========================================================
    // Pins
    assign sda_o     = sr_reg.lo;
    assign sda_oe    = sr_reg.oe;
    assign prog_busy = sr_reg.busy;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    stop_idle_a: assert property ( // R1
        stop |=> sr_reg.st == eep_pkg::S_IDLE && !sr_reg.oe
    ) else $error("stop did not return to idle");

    start_rx_a: assert property ( // R20
        start && !sup |=> sr_reg.st == eep_pkg::S_RX
            && sr_reg.cnt == '0 && sr_reg.idx == eep_pkg::IDX_DEV
    ) else $error("start did not open address phase");

    addr_nack_a: assert property ( // R3 R15
        rx_done && !start && !stop && !sup
            && sr_reg.idx == eep_pkg::IDX_DEV && (!code_ok || sr_reg.busy)
        |=> !sr_reg.oe ##1 !sr_reg.oe
    ) else $error("address acknowledged while foreign or busy");

    addr_ack_a: assert property ( // R4 R5 R6
        rx_done && !start && !stop && !sup
            && sr_reg.idx == eep_pkg::IDX_DEV && code_ok && !sr_reg.busy
        |=> sr_reg.oe && sr_reg.st == eep_pkg::S_ACK
            && sr_reg.rd == $past(sr_reg.shf[eep_pkg::DIR_BIT])
    ) else $error("matching address not acknowledged");

    wr_ack_a: assert property ( // R7
        rx_done && !start && !stop && !sup
            && sr_reg.idx != eep_pkg::IDX_DEV
        |=> sr_reg.oe && sr_reg.st == eep_pkg::S_ACK
    ) else $error("written byte not acknowledged");

    ack_release_a: assert property ( // R6 R7
        sr_reg.st == eep_pkg::S_ACK && !sr_reg.rd && fall
            && !start && !stop && !sup
        |=> !sr_reg.oe && sr_reg.st == eep_pkg::S_RX
    ) else $error("acknowledge held past ninth clock");

    page_inc_a: assert property ( // R12 R13 R24
        rx_done && !start && !stop && !sup
            && sr_reg.idx == eep_pkg::IDX_DATA
        |=> sr_reg.addr[AW-1:PW] == $past(sr_reg.addr[AW-1:PW])
            && sr_reg.addr[PW-1:0] == $past(sr_reg.addr[PW-1:0]) + 6'h01
    ) else $error("page address step wrong");

    rd_release_a: assert property ( // R8
        sr_reg.st == eep_pkg::S_TX && fall && !start && !stop && !sup
            && sr_reg.cnt == eep_pkg::TX_LAST
        |=> !sr_reg.oe && sr_reg.st == eep_pkg::S_RACK
    ) else $error("line not released after eight bits");

    rd_nack_a: assert property ( // R8
        sr_reg.st == eep_pkg::S_RACK && rise && sr_reg.val_s[1]
            && !start && !stop && !sup
        |=> sr_reg.st == eep_pkg::S_IDLE && !sr_reg.oe
    ) else $error("transmission continued without acknowledge");

    rd_next_a: assert property ( // R16 R17 R19
        load |=> sr_reg.addr == $past(sr_reg.addr) + 12'h001
            && sr_reg.shf == $past(mem_q) && sr_reg.st == eep_pkg::S_TX
    ) else $error("read pointer or data wrong");

    prog_start_a: assert property ( // R10 R14
        stop && !sup && |sr_reg.pg_vld && !sr_reg.busy
        |=> sr_reg.busy && sr_reg.commit ##1 sr_reg.pg_vld == '0
    ) else $error("programming cycle not started");

    sup_abort_a: assert property ( // R22
        sup |=> sr_reg.st == eep_pkg::S_IDLE && !sr_reg.oe
            && !sr_reg.commit
    ) else $error("transfer survived supervisor reset");

    // ==========================================================
    // Scenarios the bench is meant to reach
    page_full_c: cover property (sr_reg.commit && &sr_reg.pg_vld);
    addr_wrap_c: cover property (load && sr_reg.addr == '1); // R17
    seq_read_c: cover property (load && sr_reg.st == eep_pkg::S_RNEXT);
    poll_busy_c: cover property (
        rx_done && sr_reg.idx == eep_pkg::IDX_DEV && sr_reg.busy
    );

endmodule // eep_i2c_slave

// File: hdl/eep_pkg.sv
package eep_pkg;

    // ==========================================================
    // Array and page geometry
    localparam int         ADDR_W   = 12;
    localparam int         PAGE_W   = 6;
    localparam int         PAGE_N   = 64;
    localparam int         MEM_N    = 4096;
    localparam int         BYTE_W   = 8;
    localparam logic [7:0] ERASED   = 8'hFF;

    // ==========================================================
    // Slave address byte
    localparam logic [3:0] DEV_CODE = 4'hA;
    localparam int         DIR_BIT  = 0;
    localparam int         CODE_LSB = 4;

    // ==========================================================
    // Bit counts within a byte
    localparam logic [3:0] RX_LAST  = 4'h8;
    localparam logic [3:0] TX_LAST  = 4'h7;

    // ==========================================================
    // Programming cycle time
    localparam int         T_WR_MS  = 5;
    localparam int         CLK_KHZ  = 100000;
    localparam int         PROG_CYC = T_WR_MS * CLK_KHZ;
    localparam int         PCNT_W   = 24;

    typedef enum logic [1:0] {
        IDX_DEV,
        IDX_HI,
        IDX_LO,
        IDX_DATA
    } eep_idx_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RX,
        S_ACK,
        S_TX,
        S_RACK,
        S_RNEXT
    } eep_st_t;

    // Data line as seen at a rising serial clock edge
    typedef struct packed {
        logic val;
    } eep_lnk_t;

    typedef struct packed {
        logic [3:0]                    scl_s;
        logic [2:0]                    sda_s;
        logic [1:0]                    val_s;
        logic [1:0]                    sup_s;
        eep_st_t                       st;
        logic [3:0]                    cnt;
        eep_idx_t                      idx;
        logic                          rd;
        logic                          oe;
        logic                          lo;
        logic [BYTE_W-1:0]             shf;
        logic [ADDR_W-1:0]             addr;
        logic [PAGE_N-1:0][BYTE_W-1:0] pg_buf;
        logic [PAGE_N-1:0]             pg_vld;
        logic                          commit;
        logic                          busy;
        logic [PCNT_W-1:0]             pcnt;
    } eep_core_t;

endpackage

// File: hdl/eep_lnk_cap.sv
`timescale 1ns/1ps

// ==========================================================
// Serial clock domain: catches the data line at each rise.
// No reset on purpose: the clock may never tick while reset
// is held, and the sample is only read after a detected rise.
module eep_lnk_cap (
    input  wire logic             scl_clk,
    input  wire logic             sda_i,
    output eep_pkg::eep_lnk_t     lnk
);

    eep_pkg::eep_lnk_t sr_reg;
    eep_pkg::eep_lnk_t sr_next;

    always_comb begin
        sr_next     = sr_reg;
        sr_next.val = sda_i;
    end

    always_ff @(posedge scl_clk) begin
        sr_reg <= sr_next;
    end

    assign lnk = sr_reg;

endmodule // eep_lnk_cap

// File: verification/eep_master.sv
`timescale 1ns/1ps

// ==========================================================
// Bus master model
// The serial clock stands high between frames and runs only inside them.
// Data changes mid low phase, which keeps 20 ns of margin on each side.
module eep_master (
    output logic      scl_clk,
    output logic      pull_lo,
    input  wire logic sda
);
    initial begin
        scl_clk = 1'b1;
        pull_lo = 1'b0;
    end

    // ==========================================================
    // Framing
    task automatic start_cond();
        // Slips the link phase against the system clock on every frame
        #3;
        if (!scl_clk) begin
            #20 pull_lo = 1'b0;
            #20 scl_clk = 1'b1;
            #40;
        end
        pull_lo = 1'b1;
        #40 scl_clk = 1'b0;
    endtask

    task automatic stop_cond();
        #20 pull_lo = 1'b1;
        #20 scl_clk = 1'b1;
        #40 pull_lo = 1'b0;
        #40;
    endtask

    // ==========================================================
    // Bits and bytes, most significant bit first
    task automatic clock_bit(input logic b, output logic s);
        #20 pull_lo = ~b;
        #20 scl_clk = 1'b1;
        s = sda;
        #40 scl_clk = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
        clock_bit(1'b1, s);
        ack = ~s;
    endtask

    // Acknowledge asks for more; a missing one ends the read
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            d[i] = s;
        end
        clock_bit(~ack, s);
    endtask
endmodule // eep_master

// File: verification/test_eep_i2c_slave.sv
`timescale 1ns/1ps

module test_eep_i2c_slave;
    // Short programming cycle; still longer than one polling attempt
    localparam int PROG = 400;

    logic        clk;
    logic        rst_n;
    logic        sup_rst;
    logic        scl_clk;
    logic        pull_lo;
    logic        sda_o;
    logic        sda_oe;
    logic        prog_busy;
    wire         sda;
    int          n_fail;
    int          comparisons;
    int          seed;
    int          cycles;
    logic [7:0]  mem [eep_pkg::MEM_N];
    logic [7:0]  d;
    logic        a;
    logic [11:0] adr;
    // Device codes that must never be answered
    logic [3:0]  bad_code [4] = '{4'h0, 4'h2, 4'hB, 4'hE};

    // Open-drain wire with pull-up
    assign sda = (sda_oe ? sda_o : 1'b1) & ~pull_lo;

    eep_i2c_slave #(.PROG_CYC(PROG)) uut (
        .clk       (clk),
        .rst_n     (rst_n),
        .scl_clk   (scl_clk),
        .sda_i     (sda),
        .sup_rst   (sup_rst),
        .sda_o     (sda_o),
        .sda_oe    (sda_oe),
        .prog_busy (prog_busy)
    );

    eep_master m (
        .scl_clk (scl_clk),
        .pull_lo (pull_lo),
        .sda     (sda)
    );

    always #5 clk = ~clk;

    // ==========================================================
    // Checks and report
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail++;
            complete_run();
        end
    end

    // ==========================================================
    // Expectations and transfers
    function automatic logic [11:0] pg(input logic [11:0] b, input int k);
        pg = {b[11:6], b[5:0] + 6'(k)};
    endfunction

    task automatic sel(input logic dir, output logic ack);
        m.start_cond();
        m.send_byte({eep_pkg::DEV_CODE, 3'h0, dir}, ack);
    endtask

    // Upper nibble of the high address byte is junk on purpose
    task automatic set_ptr(input logic [11:0] ad);
        sel(1'b0, a);
        chk_bit(a, 1'b1);
        m.send_byte({4'($random(seed)), ad[11:8]}, a);
        chk_bit(a, 1'b1);
        m.send_byte(ad[7:0], a);
        chk_bit(a, 1'b1);
    endtask

    task automatic write_bytes(input logic [11:0] ad, input int n);
        logic [7:0] v;
        set_ptr(ad);
        for (int k = 0; k < n; k++) begin
            v = 8'($random(seed));
            m.send_byte(v, a);
            chk_bit(a, 1'b1);
            mem[pg(ad, k)] = v;
        end
        m.stop_cond();
    endtask

    task automatic poll();
        int k;
        k = 0;
        sel(1'b0, a);
        chk_bit(a, 1'b0);
        chk_bit(prog_busy, 1'b1);
        while (a !== 1'b1 && k < 40) begin
            m.stop_cond();
            sel(1'b0, a);
            k++;
        end
        chk_bit(a, 1'b1);
        m.stop_cond();
    endtask

    task automatic read_seq(input logic [11:0] ad, input int n,
                            input logic use_ptr);
        if (use_ptr)
            set_ptr(ad);
        sel(1'b1, a);
        chk_bit(a, 1'b1);
        for (int k = 0; k < n; k++) begin
            m.recv_byte(k < n - 1, d);
            chk_byte(d, mem[12'(ad + 12'(k))]);
        end
        // Long enough for a wrongly continued byte to show its first bit
        #40 chk_bit(sda_oe, 1'b0);
        m.stop_cond();
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sup_rst = 1'b0;
        seed = 72464;
        n_fail = 0;
        comparisons = 0;
        cycles = 0;
        foreach (mem[i]) mem[i] = eep_pkg::ERASED;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk_bit(sda_oe, 1'b0);
        chk_bit(prog_busy, 1'b0);
        $display("test reset done");

        foreach (bad_code[i]) begin
            m.start_cond();
            m.send_byte({bad_code[i], 4'($random(seed))}, a);
            chk_bit(a, 1'b0);
            m.stop_cond();
        end
        $display("test foreign address done");

        adr = 12'($random(seed));
        write_bytes(adr, 1);
        poll();
        read_seq(adr, 2, 1'b1);
        read_seq(12'(adr + 12'h2), 1, 1'b0);
        $display("test byte write done");

        adr = {6'($random(seed)), 6'h3E};
        write_bytes(adr, 66);
        poll();
        read_seq({adr[11:6], 6'h00}, 65, 1'b1);
        $display("test page write done");

        write_bytes(12'hFFF, 1);
        poll();
        read_seq(12'hFFE, 3, 1'b1);
        $display("test rollover done");

        adr = 12'($random(seed));
        set_ptr(adr);
        m.send_byte(8'($random(seed)), a);
        @(posedge clk) sup_rst <= 1'b1;
        repeat (4) @(posedge clk);
        m.stop_cond();
        sel(1'b0, a);
        chk_bit(a, 1'b0);
        chk_bit(prog_busy, 1'b0);
        m.stop_cond();
        @(posedge clk) sup_rst <= 1'b0;
        repeat (5) @(posedge clk);
        read_seq(adr, 1, 1'b1);
        $display("test supervisor reset done");
        complete_run();
    end
endmodule // test_eep_i2c_slave
